// *** hw/sfpfe_device.sv ***
// flash device end: serial decode, protection and internal write engine
// Behaviour
// - output bit driven after serial clock falls
// - input bit sampled on serial clock rise
// - deselected means output in high impedance
// - deselected and idle means standby power
// - select low gives active power state
// - ignore bus until first select falling edge
// - reset low holds reset mode, output off
// - master avoids reset during internal cycles
// - page write accepts one to 256 bytes
// - page write is page erase then program
// - large array: four sectors of 256 pages
// - small array: two sectors of 256 pages
// - erase page, subsector, sector or all
// - protection in whole 64 kilobyte sectors
// - newer variant has 4 kilobyte subsectors
// - newer variant writes three status bits only
// - level 01 protects the top sector, level 10 the top two
// - shared pin: lock older, protect newer
// - lock low refuses writes to top sector
// - protect pin freezes protect level bits
// - idle clock low or high both work
module sfpfe_device
    import sfpfe_pkg::*;
#(
    parameter int SECTORS = SECT_LARGE,
    parameter bit NEWER   = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    sfpfe_if.dev      link,
    output logic      busy_o,
    output logic      active_o,
    output logic      standby_o
);
    localparam int MEM_BYTES = SECTORS * SECTOR_BYTES;
    localparam int AW        = $clog2(MEM_BYTES);

    logic [7:0]           mem [MEM_BYTES];
    logic [7:0]           page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] loaded;

    logic [4:0]  s1;
    logic [4:0]  s2;
    logic        sclk_p;
    logic        csn_p;
    logic        armed;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_idx;
    logic [6:0]  rx_sh;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  tx_sh;
    logic        miso_q;
    logic        wel;
    logic        lvl0;
    logic        lvl1;
    logic        freeze;
    sfpfe_eng_t  eng_st;
    logic [AW-1:0] eng_ptr;
    logic [AW-1:0] eng_last;
    logic        eng_pw;

    // true when addr falls in the protected top area
    function automatic logic prot_hit(input logic [AW-1:0] a, input logic l1,
                                      input logic l0, input logic lock_n);
        logic [AW-1:0] top;
        logic          hit;
        top = a[AW-1:0] >> 16;
        hit = 1'b0;
        unique case ({l1, l0})
            2'b00: hit = 1'b0;
            2'b01: hit = (top == AW'(SECTORS - 1));
            2'b10: hit = (top >= AW'(SECTORS - 2));
            2'b11: hit = 1'b1;
        endcase
        if (!NEWER && !lock_n && top == AW'(SECTORS - 1)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // pin synchronisers {sclk, cs_n, mosi, rst_n, prot_n}
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1 <= 5'b0_1011;
            s2 <= 5'b0_1011;
        end else begin
            s1 <= {link.sclk, link.cs_n, link.mosi, link.rst_n, link.prot_n};
            s2 <= s1;
        end
    end

    logic sclk_q, csn_q, mosi_q, rstn_q, protn_q;
    assign {sclk_q, csn_q, mosi_q, rstn_q, protn_q} = s2;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_p <= 1'b0;
            csn_p  <= 1'b1;
        end else begin
            sclk_p <= sclk_q;
            csn_p  <= csn_q;
        end
    end

    // edges work for either idle level of the serial clock
    logic rise, fall, cs_fall, cs_rise, selected, busy, byte_done, whole;
    logic [7:0] rx_byte;
    assign rise      = sclk_q & ~sclk_p;
    assign fall      = ~sclk_q & sclk_p;
    assign cs_fall   = ~csn_q & csn_p;
    assign cs_rise   = csn_q & ~csn_p;
    assign selected  = armed & ~csn_q & rstn_q;
    assign busy      = (eng_st != ENG_IDLE);
    assign byte_done = selected & rise & (bit_cnt == 3'd7);
    assign rx_byte   = {rx_sh, mosi_q};
    assign whole     = (bit_cnt == 3'd0);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            armed <= 1'b0;
        end else if (cs_fall && rstn_q) begin
            armed <= 1'b1;
        end
    end

    // bit and byte counting, restarted by each select frame
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rstn_q || csn_q || cs_fall) begin
            bit_cnt  <= 3'd0;
            byte_idx <= 3'd0;
            rx_sh    <= 7'd0;
        end else if (selected && rise) begin
            bit_cnt <= bit_cnt + 3'd1;
            rx_sh   <= {rx_sh[5:0], mosi_q};
            if (bit_cnt == 3'd7 && byte_idx != 3'd4) begin
                byte_idx <= byte_idx + 3'd1;
            end
        end
    end

    logic is_page_op, wr_data;
    assign is_page_op = (opcode == OP_PW) || (opcode == OP_PP);
    assign wr_data    = byte_done && byte_idx == 3'd4 && is_page_op && !busy;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            opcode <= 8'h00;
            addr   <= 24'h00_0000;
        end else if (byte_done) begin
            unique case (byte_idx)
                3'd0: opcode <= rx_byte;
                3'd1: addr[23:16] <= rx_byte;
                3'd2: addr[15:8] <= rx_byte;
                3'd3: addr[7:0] <= rx_byte;
                default: begin
                    // page data wraps inside the page, reads run on
                    if (is_page_op) begin
                        addr[7:0] <= addr[7:0] + 8'd1;
                    end else begin
                        addr <= addr + 24'd1;
                    end
                end
            endcase
        end
    end

    logic [7:0] status;
    assign status = {freeze, 3'b000, lvl1, lvl0, wel, busy};

    // output shifter: loaded at byte end, shifted out on falling clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || cs_fall || !selected) begin
            tx_sh  <= 8'h00;
            miso_q <= 1'b0;
        end else if (byte_done) begin
            if ((byte_idx == 3'd0 && rx_byte == OP_RDSR) ||
                (byte_idx != 3'd0 && opcode == OP_RDSR)) begin
                tx_sh <= status;
            end else if (opcode == OP_READ && !busy && byte_idx == 3'd3) begin
                tx_sh <= mem[AW'({addr[23:8], rx_byte})];
            end else if (opcode == OP_READ && !busy && byte_idx == 3'd4) begin
                tx_sh <= mem[AW'(addr + 24'd1)];
            end else begin
                tx_sh <= 8'h00;
            end
        end else if (fall) begin
            miso_q <= tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
        end
    end

    // command execution when the frame closes
    logic exec, do_wrsr, do_pw, do_pp, do_er;
    logic [AW-1:0] er_mask, tgt_base, tgt_last;
    assign exec    = cs_rise && armed && rstn_q && !busy && whole;
    assign do_wrsr = exec && NEWER && wel && opcode == OP_WRSR && byte_idx >= 3'd2;

    always_comb begin
        er_mask = AW'(PAGE_BYTES - 1);
        do_er   = 1'b0;
        if (byte_idx == 3'd4) begin
            unique case (opcode)
                OP_PE:   do_er = 1'b1;
                OP_SSE:  begin
                    do_er   = NEWER;
                    er_mask = AW'(SUBSECT_BYTES - 1);
                end
                OP_SE:   begin
                    do_er   = 1'b1;
                    er_mask = AW'(SECTOR_BYTES - 1);
                end
                default: do_er = 1'b0;
            endcase
        end
        if (opcode == OP_BE && byte_idx == 3'd1) begin
            do_er   = 1'b1;
            er_mask = AW'(MEM_BYTES - 1);
        end
        tgt_base = AW'(addr) & ~er_mask;
        tgt_last = tgt_base | er_mask;
    end

    // protection is judged by the last byte, since regions grow from the top
    logic allowed;
    assign allowed = exec && wel && !prot_hit(tgt_last, lvl1, lvl0, protn_q);
    assign do_pw   = allowed && opcode == OP_PW && |loaded;
    assign do_pp   = allowed && opcode == OP_PP && |loaded;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rstn_q) begin
            wel <= 1'b0;
        end else if (exec && opcode == OP_WREN && byte_idx == 3'd1) begin
            wel <= 1'b1;
        end else if (exec && opcode != OP_RDSR && opcode != OP_READ) begin
            wel <= 1'b0;
        end
    end

    // protect pin low freezes the levels once status_freeze is set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lvl0   <= 1'b0;
            lvl1   <= 1'b0;
            freeze <= 1'b0;
        end else if (do_wrsr && !(freeze && !protn_q)) begin
            lvl0   <= addr[16 + ST_LVL0];
            lvl1   <= addr[16 + ST_LVL1];
            freeze <= addr[16 + ST_FREEZE];
        end
    end

    // internal cycle; reset pin aborts it and the page may be lost
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rstn_q) begin
            eng_st   <= ENG_IDLE;
            eng_ptr  <= '0;
            eng_last <= '0;
            eng_pw   <= 1'b0;
        end else begin
            unique case (eng_st)
                ENG_IDLE: begin
                    eng_ptr  <= tgt_base;
                    eng_last <= tgt_last;
                    eng_pw   <= do_pw;
                    if (do_pw) begin
                        eng_st <= ENG_FILL;
                    end else if (do_pp) begin
                        eng_st <= ENG_PROG;
                    end else if (do_er && allowed) begin
                        eng_st <= ENG_ERASE;
                    end
                end
                ENG_FILL, ENG_ERASE: begin
                    if (eng_ptr == eng_last) begin
                        eng_ptr <= eng_ptr & ~AW'(PAGE_BYTES - 1);
                        eng_st  <= (eng_st == ENG_FILL) ? ENG_ERASE :
                                   (eng_pw ? ENG_PROG : ENG_IDLE);
                    end else begin
                        eng_ptr <= eng_ptr + AW'(1);
                    end
                end
                ENG_PROG: begin
                    if (eng_ptr == eng_last) begin
                        eng_st <= ENG_IDLE;
                    end else begin
                        eng_ptr <= eng_ptr + AW'(1);
                    end
                end
            endcase
        end
    end

    // array and page buffer, no reset on storage
    logic [7:0] pi;
    assign pi = eng_ptr[7:0];
    always_ff @(posedge clk_i) begin
        if (wr_data) begin
            page_buf[addr[7:0]] <= rx_byte;
        end else if (eng_st == ENG_FILL && !loaded[pi]) begin
            page_buf[pi] <= mem[eng_ptr];
        end
        if (eng_st == ENG_ERASE) begin
            mem[eng_ptr] <= ERASED_BYTE;
        end else if (eng_st == ENG_PROG && (eng_pw || loaded[pi])) begin
            mem[eng_ptr] <= eng_pw ? page_buf[pi] : (mem[eng_ptr] & page_buf[pi]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || (cs_fall && !busy)) begin
            loaded <= '0;
        end else if (wr_data) begin
            loaded[addr[7:0]] <= 1'b1;
        end
    end

    assign link.miso_drv = miso_q;
    assign link.miso_oe  = selected;
    assign busy_o        = busy;
    assign active_o      = selected;
    assign standby_o     = ~selected & ~busy;
endmodule // sfpfe_device

// *** hw/sfpfe_pkg.sv ***
// shared constants and types for the serial flash port front end
package sfpfe_pkg;
    // array organisation
    localparam int PAGE_BYTES     = 256;
    localparam int PAGES_PER_SECT = 256;
    localparam int SECT_LARGE     = 4;
    localparam int SECT_SMALL     = 2;
    localparam int SECTOR_BYTES   = PAGE_BYTES * PAGES_PER_SECT;
    localparam int SUBSECT_BYTES  = 4096;
    localparam int ADDR_BYTES     = 3;

    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PW   = 8'h0A;
    localparam logic [7:0] OP_PP   = 8'h02;
    localparam logic [7:0] OP_PE   = 8'hDB;
    localparam logic [7:0] OP_SSE  = 8'h20;
    localparam logic [7:0] OP_SE   = 8'hD8;
    localparam logic [7:0] OP_BE   = 8'hC7;

    // status byte layout
    localparam int ST_BUSY   = 0;
    localparam int ST_WEL    = 1;
    localparam int ST_LVL0   = 2;
    localparam int ST_LVL1   = 3;
    localparam int ST_FREEZE = 7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // host register map (byte addresses) and control fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX   = 8'h04;
    localparam logic [7:0] REG_RX   = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam int CTRL_SEL   = 0;
    localparam int CTRL_CPOL  = 1;
    localparam int CTRL_RST   = 2;
    localparam int CTRL_PROT  = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // serial clock timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int SCLK_PERIOD_NS = 80;
    localparam int HALF_SCLK_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    typedef enum logic [1:0] {ENG_IDLE, ENG_FILL, ENG_ERASE, ENG_PROG} sfpfe_eng_t;
endpackage

// *** hw/sfpfe_if.sv ***
// serial link between flash device end and bus master end
interface sfpfe_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_drv;
    logic miso_oe;
    logic rst_n;
    logic prot_n;
    logic miso_bus;

    // line has a weak pull-down when nobody drives it
    assign miso_bus = miso_oe & miso_drv;

    modport dev  (input sclk, cs_n, mosi, rst_n, prot_n, output miso_drv, miso_oe);
    modport host (output sclk, cs_n, mosi, rst_n, prot_n, input miso_bus);
endinterface

// *** hw/sfpfe_host.sv ***
// bus master end: APB register front, serial byte shifter
module sfpfe_host
    import sfpfe_pkg::*;
#(
    parameter int HALF_CYC = HALF_SCLK_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    sfpfe_if.host            link
);
    logic [3:0]  ctrl;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_sh;
    logic        busy;
    logic [15:0] div_cnt;
    logic [3:0]  half;
    logic        sclk_q;
    logic        mosi_q;
    logic [1:0]  miso_s;

    function automatic logic mapped(input logic [7:0] a);
        return (a == REG_CTRL) || (a == REG_TX) || (a == REG_RX) || (a == REG_STAT);
    endfunction

    logic setup, wr, start, tick;
    assign setup = psel_i & ~penable_i;
    assign wr    = psel_i & penable_i & pwrite_i & mapped(paddr_i);
    assign start = wr && paddr_i == REG_TX && !busy && ctrl[CTRL_SEL];
    assign tick  = busy && div_cnt == 16'(HALF_CYC - 1);

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);

    // read data captured in the setup cycle so it is a flop at access
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            unique case (paddr_i)
                REG_CTRL: prdata_o <= {28'h000_0000, ctrl};
                REG_RX:   prdata_o <= {24'h00_0000, rx_byte};
                REG_STAT: prdata_o <= {31'h0000_0000, busy};
                default:  prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= CTRL_RESET;
        end else if (wr && paddr_i == REG_CTRL) begin
            ctrl <= pwdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            miso_s <= 2'b00;
        end else begin
            miso_s <= {miso_s[0], link.miso_bus};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !busy || tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // 16 half periods: even halves clock low, odd halves clock high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy    <= 1'b0;
            half    <= 4'h0;
            sclk_q  <= 1'b0;
            mosi_q  <= 1'b0;
            tx_sh   <= 8'h00;
            rx_byte <= 8'h00;
        end else if (start) begin
            busy   <= 1'b1;
            half   <= 4'h0;
            sclk_q <= 1'b0;
            mosi_q <= pwdata_i[7];
            tx_sh  <= {pwdata_i[6:0], 1'b0};
        end else if (tick) begin
            half <= half + 4'h1;
            if (half == 4'hF) begin
                busy   <= 1'b0;
                sclk_q <= ctrl[CTRL_CPOL];
            end else begin
                sclk_q <= ~half[0];
            end
            if (half[0]) begin
                // late sample leaves room for the device's pin delay
                rx_byte <= {rx_byte[6:0], miso_s[1]};
                if (half != 4'hF) begin
                    mosi_q <= tx_sh[7];
                    tx_sh  <= {tx_sh[6:0], 1'b0};
                end
            end
        end else if (!busy) begin
            sclk_q <= ctrl[CTRL_CPOL];
        end
    end

    assign link.sclk   = sclk_q;
    assign link.mosi   = mosi_q;
    assign link.cs_n   = ~ctrl[CTRL_SEL];
    assign link.rst_n  = ~ctrl[CTRL_RST];
    assign link.prot_n = ~ctrl[CTRL_PROT];
endmodule // sfpfe_host

// *** tb/sfpfe_assertions.sv ***
// link checks between the host end and the device end
module sfpfe_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_drv,
    input wire logic miso_oe,
    input wire logic rst_n,
    input wire logic busy_o,
    input wire logic active_o,
    input wire logic standby_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence sel_fall_s;
        $fell(cs_n) && rst_n;
    endsequence
    sequence sel_held_s;
        (!cs_n && rst_n) [*4];
    endsequence

    select_active_a: assert property (sel_fall_s ##1 sel_held_s |-> active_o)
        else $error("inactive while selected");
    deselect_off_a: assert property (cs_n [*5] |-> !miso_oe && !active_o)
        else $error("driving while deselected");
    standby_mode_a: assert property (cs_n [*5] |-> standby_o == !busy_o)
        else $error("standby wrong");
    reset_mode_a: assert property (!rst_n [*5] |-> !miso_oe && !active_o && !busy_o)
        else $error("reset mode not held");
    // the device only sees sclk through synchronisers, so allow for its lag
    out_hold_a: assert property (!cs_n && $past(miso_oe) && sclk && $past(sclk)
        |-> $stable(miso_drv)) else $error("output moved while clock high");
    in_hold_a: assert property ($rose(sclk) && !cs_n |-> $stable(mosi) [*5])
        else $error("input moved while clock high");
    busy_start_a: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 2))
        else $error("cycle began inside a frame");
    enable_select_a: assert property ($rose(miso_oe) |-> !cs_n && !$past(cs_n, 2))
        else $error("output enabled without select");
endmodule // sfpfe_assertions

// *** tb/serial_flash_port_front_end_bench.sv ***
// bench: host end over APB talks to the device end across the link
module serial_flash_port_front_end_bench
    import sfpfe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, busy_o, active_o, standby_o, perr;
    logic [31:0] ctl = 32'h0000_0000;
    logic [7:0]  txq[$], rxq[$];
    int          busy_cycles = 0, busy_run, errors = 0, comparisons = 0;

    sfpfe_if link_if ();
    sfpfe_host sfpfe_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link_if.host));
    sfpfe_device #(.SECTORS(SECT_SMALL), .NEWER(1'b1)) sfpfe_device_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .link(link_if.dev), .busy_o(busy_o), .active_o(active_o),
        .standby_o(standby_o));
    sfpfe_assertions sfpfe_assertions_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
        .miso_drv(link_if.miso_drv), .miso_oe(link_if.miso_oe), .rst_n(link_if.rst_n),
        .busy_o(busy_o), .active_o(active_o), .standby_o(standby_o));

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    always @(posedge clk_i) if (busy_o === 1'b1) busy_cycles <= busy_cycles + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata_o;
        perr = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one select frame; the next byte waits for the shifter to go idle
    task automatic frame();
        int n;
        rxq = {};
        ctl[CTRL_SEL] = 1'b1;
        apb(REG_CTRL, 1'b1, ctl);
        foreach (txq[i]) begin
            apb(REG_TX, 1'b1, {24'h00_0000, txq[i]});
            n = 0;
            do begin
                apb(REG_STAT, 1'b0, 32'h0000_0000);
                n++;
            end while (rd[0] !== 1'b0 && n < 60);
            if (n >= 60) errors++;
            apb(REG_RX, 1'b0, 32'h0000_0000);
            rxq.push_back(rd[7:0]);
        end
        ctl[CTRL_SEL] = 1'b0;
        apb(REG_CTRL, 1'b1, ctl);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (8) @(posedge clk_i);
        while (busy_o === 1'b1 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20000) errors++;
    endtask

    task automatic modify(input logic w = 1'b1);
        logic [7:0] keep[$];
        int         start;
        keep = txq;
        txq = '{OP_WREN};
        frame();
        txq = keep;
        start = busy_cycles;
        frame();
        if (w) wait_idle();
        busy_run = busy_cycles - start;
    endtask

    task automatic status(input logic [7:0] mask, input logic [7:0] exp);
        txq = '{OP_RDSR, 8'h00};
        frame();
        check(rxq[1] & mask, exp);
    endtask

    task automatic read2(input logic [23:0] a, input logic [15:0] exp);
        txq = '{OP_READ, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00};
        frame();
        check({rxq[4], rxq[5]}, exp);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check({link_if.miso_oe, active_o, standby_o}, 3'h1);
        apb(REG_CTRL, 1'b0, 32'h0000_0000);
        check(rd, {28'h000_0000, CTRL_RESET});
        apb(8'h10, 1'b0, 32'h0000_0000);
        check(perr, 1'b1);
        for (int p = 0; p < 2; p++) begin
            ctl[CTRL_CPOL] = p[0];
            apb(REG_CTRL, 1'b1, ctl);
            status(8'hFF, 8'h00);
            txq = '{OP_WREN};
            frame();
            status(8'hFF, 8'h01 << ST_WEL);
            txq = '{OP_PW, 8'h00, 8'h01, 8'h10, 8'hA5, 8'h3C};
            frame();
            repeat (8) @(posedge clk_i);
            check({busy_o, standby_o}, 2'h2);
            status(8'h01 << ST_BUSY, 8'h01 << ST_BUSY);
            wait_idle();
            read2(24'h00_0110, 16'hA53C);
        end
        txq = '{OP_PP, 8'h00, 8'h01, 8'h10, 8'h0F};
        modify();
        check(busy_run < 3 * PAGE_BYTES, 1'b1);
        read2(24'h00_0110, 16'h053C);
        txq = '{OP_PW, 8'h00, 8'h01, 8'h10, 8'hF0};
        modify();
        check(busy_run >= 3 * PAGE_BYTES, 1'b1);
        read2(24'h00_0110, 16'hF03C);
        txq = '{OP_WRSR, 8'hFF};
        modify();
        status(8'hFF, 8'h8C);
        ctl[CTRL_PROT] = 1'b1;
        txq = '{OP_WRSR, 8'h04};
        modify();
        status(8'hFD, 8'h8C);
        ctl[CTRL_PROT] = 1'b0;
        txq = '{OP_WRSR, 8'h04};
        modify();
        status(8'hFF, 8'h04);
        for (int k = 0; k < 3; k++) begin
            case (k)
                0: txq = '{OP_PW, 8'h01, 8'h00, 8'h00, 8'h00};
                1: txq = '{OP_SE, 8'h01, 8'h00, 8'h00};
                default: txq = '{OP_BE};
            endcase
            modify();
            check(busy_run, 0);
        end
        txq = '{OP_PE, 8'h00, 8'h01, 8'h00};
        modify();
        read2(24'h00_0110, {ERASED_BYTE, ERASED_BYTE});
        txq = '{OP_SSE, 8'h00, 8'h00, 8'h00};
        modify();
        check(busy_run >= SUBSECT_BYTES, 1'b1);
        txq = '{OP_PW, 8'h00, 8'h01, 8'h10, 8'h11};
        modify(1'b0);
        repeat (20) @(posedge clk_i);
        check({busy_o, standby_o}, 2'h2);
        // pulling the reset pin mid-cycle would corrupt the page, so let it finish
        wait_idle();
        ctl[CTRL_RST] = 1'b1;
        apb(REG_CTRL, 1'b1, ctl);
        repeat (6) @(posedge clk_i);
        check({busy_o, link_if.miso_oe, active_o}, 3'h0);
        ctl[CTRL_RST] = 1'b0;
        apb(REG_CTRL, 1'b1, ctl);
        status(8'hFF, 8'h04);
        read2(24'h00_0110, 16'h11FF);
        results();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        results();
    end
endmodule // serial_flash_port_front_end_bench
